// [ddpau_defs.vh]
// Overview of operation
// [RL1] Select bit picks pointer; alternate uses other
// [RL2] Prefix inverts select, except indirect jump
// [RL3] Auto-update one post-steps pointer one
// [RL4] Auto-update zero post-steps pointer zero
// [RL5] Decrement one turns increment into decrement
// [RL6] Decrement zero turns increment into decrement
// [RL7] Config upper bits reset zero, lower undefined
// [RL8] Redirect moves via pointer one to B
// [RL9] Index disable drops accumulator from code read
// [RL10] Redirect never replaces the index accumulator
// [RL11] Circular enables per pointer
// [RL12] Two regions sized by length register
// [RL13] Increment at region top wraps to base
// [RL14] Decrement at region base wraps to top
// [RL15] Wrap applies to explicit and auto updates
// [RL16] Outside regions pointers step normally
// [RL17] Wrap applies in whichever region pointer lies
// [RL18] Software clears modes before programming routines
// [RL19] A5 90 loads constant into alternate pointer
// [RL20] A5 93 indexed code read via alternate
// [RL21] A5 A3 steps alternate pointer
// [RL22] A5 E0 external read via alternate
// [RL23] A5 F0 external write via alternate
// [RL24] Post-update after access uses original value
`ifndef DDPAU_DEFS_VH
`define DDPAU_DEFS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
// Printed offsets are register indices; the byte address is four times the index
`define DDPAU_IDX_PTR_CONFIG  10'h0A1
`define DDPAU_IDX_CIRC_LEN    10'h0E3
`define DDPAU_OFF_PTR_CONFIG  {`DDPAU_IDX_PTR_CONFIG, 2'b00}
`define DDPAU_OFF_CIRC_LEN    {`DDPAU_IDX_CIRC_LEN, 2'b00}
`define DDPAU_OFF_MODE        12'h100
`define DDPAU_OFF_PTR_ZERO    12'h104
`define DDPAU_OFF_PTR_ONE     12'h108
`define DDPAU_OFF_SELECT      12'h10C
// ----------------------------------------
// Field positions, reset values and region bases
// ----------------------------------------
`define DDPAU_CFG_AUTO_ONE    7
`define DDPAU_CFG_AUTO_ZERO   6
`define DDPAU_CFG_DEC_ONE     5
`define DDPAU_CFG_DEC_ZERO    4
`define DDPAU_MODE_REDIR_B    0
`define DDPAU_MODE_IDX_DIS    1
`define DDPAU_MODE_CIRC_ZERO  2
`define DDPAU_MODE_CIRC_ONE   3
`define DDPAU_CFG_RESET       4'h0
`define DDPAU_MODE_RESET      4'h0
`define DDPAU_LEN_RESET       8'h00
`define DDPAU_REGION_B_BASE   16'h0100
`define DDPAU_REGION_A_BASE   16'h0000
// ----------------------------------------
// Opcodes, instruction lengths and cycle counts
// ----------------------------------------
`define DDPAU_OP_PREFIX       8'hA5
`define DDPAU_OP_LOAD         8'h90
`define DDPAU_OP_CODE_READ    8'h93
`define DDPAU_OP_INC          8'hA3
`define DDPAU_OP_XREAD        8'hE0
`define DDPAU_OP_XWRITE       8'hF0
`define DDPAU_OP_JMP_IND      8'h73
`define DDPAU_LEN_LOAD        3'h4
`define DDPAU_LEN_SHORT       3'h2
`define DDPAU_CYC_LOAD        3'h4
`define DDPAU_CYC_CODE_READ   3'h4
`define DDPAU_CYC_INC         3'h3
`define DDPAU_CYC_XFER_FAST   3'h3
`define DDPAU_CYC_XFER_SLOW   3'h5
`endif

// [ddpau_top.v]
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "ddpau_defs.vh"
module ddpau_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ins_valid,
  input  wire        ins_prefix,
  input  wire [7:0]  ins_opcode,
  input  wire [15:0] ins_imm,
  input  wire [7:0]  acc_value,
  input  wire        xmem_slow,
  output reg  [15:0] mem_addr,
  output reg         mem_code,
  output reg         mem_ext_rd,
  output reg         mem_ext_wr,
  output reg         use_b_reg,
  output reg         jump_valid,
  output reg  [2:0]  ins_bytes,
  output reg  [2:0]  ins_cycles,
  output reg         ins_done
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [3:0]  cfg_q;
  reg [3:0]  mode_q;
  reg [7:0]  len_q;
  reg [15:0] ptr0_q;
  reg [15:0] ptr1_q;
  reg        sel_q;
  wire auto_one  = cfg_q[`DDPAU_CFG_AUTO_ONE - 4];
  wire auto_zero = cfg_q[`DDPAU_CFG_AUTO_ZERO - 4];
  wire dec_one   = cfg_q[`DDPAU_CFG_DEC_ONE - 4];
  wire dec_zero  = cfg_q[`DDPAU_CFG_DEC_ZERO - 4];
  wire redir_b   = mode_q[`DDPAU_MODE_REDIR_B];
  wire idx_dis   = mode_q[`DDPAU_MODE_IDX_DIS];
  wire circ_zero = mode_q[`DDPAU_MODE_CIRC_ZERO];
  wire circ_one  = mode_q[`DDPAU_MODE_CIRC_ONE];
  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  wire apb_wr = psel & penable & pwrite;
  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire op_load  = ins_opcode == `DDPAU_OP_LOAD;
  wire op_code  = ins_opcode == `DDPAU_OP_CODE_READ;
  wire op_inc   = ins_opcode == `DDPAU_OP_INC;
  wire op_xrd   = ins_opcode == `DDPAU_OP_XREAD;
  wire op_xwr   = ins_opcode == `DDPAU_OP_XWRITE;
  wire op_jmp   = ins_opcode == `DDPAU_OP_JMP_IND;
  // Indirect jump ignores the prefix
  wire use_one  = op_jmp ? sel_q : (sel_q ^ ins_prefix); // [RL1] [RL2]
  wire [15:0] ptr_cur = use_one ? ptr1_q : ptr0_q;
  wire dec_cur  = use_one ? dec_one : dec_zero;
  wire circ_cur = use_one ? circ_one : circ_zero;
  wire auto_cur = use_one ? auto_one : auto_zero;
  wire access   = op_code | op_xrd | op_xwr;
  wire step     = ins_valid & (op_inc | (access & auto_cur)); // [RL3] [RL4] [RL15]
  // ----------------------------------------
  // Step with circular wrap
  // ----------------------------------------
  wire [15:0] top_a = {8'h00, len_q};
  wire [15:0] top_b = `DDPAU_REGION_B_BASE | {8'h00, len_q};
  reg  [15:0] ptr_next;
  always @* begin
    ptr_next = dec_cur ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001; // [RL5] [RL6] [RL16]
    if (circ_cur) begin // [RL11] [RL17]
      if (!dec_cur && ptr_cur == top_a)
        ptr_next = `DDPAU_REGION_A_BASE; // [RL12] [RL13]
      else if (!dec_cur && ptr_cur == top_b)
        ptr_next = `DDPAU_REGION_B_BASE; // [RL13]
      else if (dec_cur && ptr_cur == `DDPAU_REGION_A_BASE)
        ptr_next = top_a; // [RL14]
      else if (dec_cur && ptr_cur == `DDPAU_REGION_B_BASE)
        ptr_next = top_b; // [RL14]
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      cfg_q  <= `DDPAU_CFG_RESET; // [RL7]
      mode_q <= `DDPAU_MODE_RESET;
      len_q  <= `DDPAU_LEN_RESET;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      sel_q  <= 1'b0;
    end else begin
      if (apb_wr) begin
        if (paddr == `DDPAU_OFF_PTR_CONFIG)
          cfg_q <= pwdata[7:4];
        else if (paddr == `DDPAU_OFF_CIRC_LEN)
          len_q <= pwdata[7:0];
        else if (paddr == `DDPAU_OFF_MODE)
          mode_q <= pwdata[3:0];
        else if (paddr == `DDPAU_OFF_SELECT)
          sel_q <= pwdata[0];
      end
      // Core instruction outranks a bus write to the same pointer
      if (apb_wr && paddr == `DDPAU_OFF_PTR_ZERO)
        ptr0_q <= pwdata[15:0];
      if (apb_wr && paddr == `DDPAU_OFF_PTR_ONE)
        ptr1_q <= pwdata[15:0];
      if (ins_valid && op_load) begin
        if (use_one)
          ptr1_q <= ins_imm; // [RL19]
        else
          ptr0_q <= ins_imm;
      end else if (step) begin
        // Access below already used the old value
        if (use_one)
          ptr1_q <= ptr_next; // [RL24]
        else
          ptr0_q <= ptr_next;
      end
    end
  end
  // ----------------------------------------
  // Access outputs, one cycle after issue
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      mem_addr   <= 16'h0000;
      mem_code   <= 1'b0;
      mem_ext_rd <= 1'b0;
      mem_ext_wr <= 1'b0;
      use_b_reg  <= 1'b0;
      jump_valid <= 1'b0;
      ins_bytes  <= 3'h0;
      ins_cycles <= 3'h0;
      ins_done   <= 1'b0;
    end else begin
      ins_done   <= ins_valid;
      mem_code   <= ins_valid & op_code; // [RL20]
      mem_ext_rd <= ins_valid & op_xrd; // [RL22]
      mem_ext_wr <= ins_valid & op_xwr; // [RL23]
      jump_valid <= ins_valid & op_jmp;
      // Accumulator stays the index even when B is the destination
      use_b_reg  <= ins_valid & access & redir_b & use_one; // [RL8] [RL10]
      if (op_code | op_jmp)
        mem_addr <= (op_code & idx_dis) ? ptr_cur : ptr_cur + {8'h00, acc_value}; // [RL9]
      else
        mem_addr <= ptr_cur;
      ins_bytes  <= op_load ? (ins_prefix ? `DDPAU_LEN_LOAD : 3'h3) :
                    (ins_prefix ? `DDPAU_LEN_SHORT : 3'h1);
      if (op_load)
        ins_cycles <= `DDPAU_CYC_LOAD;
      else if (op_code)
        ins_cycles <= `DDPAU_CYC_CODE_READ;
      else if (op_inc)
        ins_cycles <= `DDPAU_CYC_INC; // [RL21]
      else if (op_xrd | op_xwr)
        ins_cycles <= xmem_slow ? `DDPAU_CYC_XFER_SLOW : `DDPAU_CYC_XFER_FAST;
      else
        ins_cycles <= 3'h0;
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      if (paddr == `DDPAU_OFF_PTR_CONFIG)
        prdata <= {24'h000000, cfg_q, 4'h0};
      else if (paddr == `DDPAU_OFF_CIRC_LEN)
        prdata <= {24'h000000, len_q};
      else if (paddr == `DDPAU_OFF_MODE)
        prdata <= {28'h0000000, mode_q};
      else if (paddr == `DDPAU_OFF_PTR_ZERO)
        prdata <= {16'h0000, ptr0_q};
      else if (paddr == `DDPAU_OFF_PTR_ONE)
        prdata <= {16'h0000, ptr1_q};
      else if (paddr == `DDPAU_OFF_SELECT)
        prdata <= {31'h00000000, sel_q};
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule

// [ddpau_chk.sv]
`timescale 1ns/1ps
module ddpau_chk (
  input wire        ref_clk,
  input wire        rst,
  input wire        ins_valid,
  input wire        ins_prefix,
  input wire [7:0]  ins_opcode,
  input wire        xmem_slow,
  input wire        mem_code,
  input wire        mem_ext_rd,
  input wire        mem_ext_wr,
  input wire        jump_valid,
  input wire [2:0]  ins_bytes,
  input wire [2:0]  ins_cycles,
  input wire        ins_done
);
  // ----
  // Decode results one cycle after issue
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire       pg = ins_valid && ins_prefix;
  wire [7:0] op = ins_opcode;
  a_done_follow: assert property (ins_valid |=> ins_done)
    else $error("done missing after issue");
  a_done_cause: assert property (!ins_valid |=> !ins_done)
    else $error("done without issue");
  a_load_decode: assert property (pg && op == 8'h90 |=> ins_bytes == 3'h4
    && ins_cycles == 3'h4 && !mem_code) else $error("load decode wrong");
  a_code_decode: assert property (pg && op == 8'h93 |=> mem_code
    && ins_bytes == 3'h2 && ins_cycles == 3'h4) else $error("code read decode wrong");
  a_inc_decode: assert property (pg && op == 8'hA3 |=> !mem_ext_rd && !mem_ext_wr
    && ins_bytes == 3'h2 && ins_cycles == 3'h3) else $error("step decode wrong");
  a_xread_decode: assert property (pg && op == 8'hE0 |=> mem_ext_rd && !mem_ext_wr
    && ins_cycles == ($past(xmem_slow) ? 3'h5 : 3'h3)) else $error("ext read decode wrong");
  a_xwrite_decode: assert property (pg && op == 8'hF0 |=> mem_ext_wr && !mem_ext_rd
    && ins_cycles == ($past(xmem_slow) ? 3'h5 : 3'h3)) else $error("ext write decode wrong");
  a_jump_prefix: assert property (ins_valid && op == 8'h73 |=> jump_valid && !mem_code)
    else $error("jump decode wrong");
endmodule
bind ddpau_top ddpau_chk i_chk (.*);

// [ddpau_cpu.sv]
`timescale 1ns/1ps
module ddpau_cpu (
  input  wire         ref_clk,
  output logic        ins_valid,
  output logic        ins_prefix,
  output logic [7:0]  ins_opcode,
  output logic [15:0] ins_imm,
  output logic [7:0]  acc_value,
  output logic        xmem_slow
);
  initial {ins_valid, ins_prefix, ins_opcode, ins_imm, acc_value, xmem_slow} = '0;
  task automatic issue(input logic p, input logic [7:0] o, input logic [15:0] im,
                       input logic [7:0] a, input logic s);
    @(posedge ref_clk);
    ins_valid  <= 1'b1;
    ins_prefix <= p;
    ins_opcode <= o;
    ins_imm    <= im;
    acc_value  <= a;
    xmem_slow  <= s;
    @(posedge ref_clk);
    // Idle fields other than ins_prefix flip so a stale value is never mistaken for a held one
    ins_valid  <= 1'b0;
    ins_opcode <= ~o;
    ins_imm    <= ~im;
    acc_value  <= ~a;
    xmem_slow  <= ~s;
  endtask
endmodule

// [ddpau_top_tb.sv]
`timescale 1ns/1ps
module ddpau_top_tb;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        ins_valid, ins_prefix, xmem_slow, mem_code, mem_ext_rd, mem_ext_wr;
  logic        use_b_reg, jump_valid, ins_done, n;
  logic [7:0]  ins_opcode, acc_value, cfg, md, ln, op;
  logic [15:0] ins_imm, mem_addr, im;
  logic [15:0] p[2];
  logic [2:0]  ins_bytes, ins_cycles;
  logic [31:0] exp_q[$];
  logic [7:0]  ops[5] = '{8'h90, 8'h93, 8'hA3, 8'hE0, 8'hF0};
  int          bad_count, samples_checked, cyc;
  ddpau_top i_dut (.*);
  ddpau_cpu i_cpu (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ----
  // Bus cycles and checking
  // ----
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~ad;
    pwdata  <= ~d;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] v);
    logic [31:0] e;
    e = exp_q.pop_front();
    samples_checked++;
    if (v !== e) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, e, v);
    end
  endtask
  always @(posedge ref_clk) begin
    if (psel && penable && !pwrite) chk("prdata", prdata);
    if (mem_code || mem_ext_rd || mem_ext_wr) chk("mem_addr", {15'h0, use_b_reg, mem_addr});
  end
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // Reference stepping, boundary cases drawn often to reach the wraps
  function automatic logic [15:0] nxt(input logic [15:0] v, input logic d, c);
    if (c && !d && v[15:9] == 7'h00 && v[7:0] == ln) return {7'h00, v[8], 8'h00};
    if (c && d && v[15:9] == 7'h00 && v[7:0] == 8'h00) return {7'h00, v[8], ln};
    return d ? v - 16'h0001 : v + 16'h0001;
  endfunction
  function automatic logic [15:0] pick;
    logic [31:0] q;
    q = $urandom;
    return q[1] ? q[31:16] : {7'h00, q[2], q[3] ? ln : 8'h00};
  endfunction
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    void'($urandom(32'hEEF40DD9));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(12'h284, 32'h0);
    rd(12'h38C, 32'h0);
    rd(12'h104, 32'h0);
    apb(1'b1, 12'h284, 32'hFF);
    rd(12'h284, 32'hF0);
    rd(12'h200, 32'h0);
    i_cpu.issue(1'b1, 8'h73, 16'h0, 8'h0, 1'b0);
    repeat (200) begin
      r = $urandom;
      im = $urandom;
      cfg = {r[7:4], 4'h0};
      md = {4'h0, r[3:0]};
      ln = r[15:8];
      op = ops[r[20:18] % 5];
      p[0] = pick();
      p[1] = pick();
      apb(1'b1, 12'h284, 32'(cfg));
      apb(1'b1, 12'h100, 32'(md));
      apb(1'b1, 12'h38C, 32'(ln));
      apb(1'b1, 12'h10C, 32'(r[16]));
      apb(1'b1, 12'h104, 32'(p[0]));
      apb(1'b1, 12'h108, 32'(p[1]));
      n = r[16] ^ r[17];
      if (op != 8'hA3 && op != 8'h90)
        exp_q.push_back({15'h0, md[0] & n, p[n] + ((op == 8'h93 && !md[1]) ? r[31:24] : 8'h00)});
      i_cpu.issue(r[17], op, im, r[31:24], r[21]);
      if (op == 8'h90) p[n] = im;
      else if (op == 8'hA3 || cfg[6 + n]) p[n] = nxt(p[n], cfg[4 + n], md[2 + n]);
      rd(12'h104, {16'h0, p[0]});
      rd(12'h108, {16'h0, p[1]});
    end
    apb(1'b1, 12'h100, 32'h0);
    complete_run();
  end
endmodule
